// ---- common/dcfg_consts.svh ----
// register offsets, reset values, write masks and sizes of the datapath config bank
// assumes a byte-wide register port on the core clock
// Summary of operation
// R01 - tuning word bytes 31:24 at 0x117, 39:32 at 0x118, reset zero
// R02 - tuning word bits 47:40 at 0x119, reset value 0x10
// R03 - 16-bit oscillator phase offset, low byte 0x11A, high 0x11B, reset zero
// R04 - 13-bit phase compensation word, bits 7:0 at 0x11C, 12:8 at 0x11D
// R05 - sequencer control bit 0 enables transmit sequencer, resets to one
// R06 - bit 1 set routes shared pin to amplifier control, not sync; resets one
// R07 - bit 2 inverts external modulator control polarity, resets zero
// R08 - amplifier fall control bits 7:6 reset 2, rise control bits 5:4 reset 0
// R09 - software writes 0x8B to setup register 0x12D; reset 0x46 is unusable
// R10 - auxiliary converter powered only while 0x12F bit 0 is one
// R11 - read-only 16-bit converter reading, low byte 0x132, high 0x133
// R12 - setting refresh bit 0x134 captures a new temperature code
// R13 - DC offset correction applied only while 0x135 bit 0 is one
// R14 - 16-bit coarse offsets: I at 0x136/0x137, Q at 0x138/0x139
// R15 - 5-bit fine I offset in 0x13A bits 4:0, upper bits read zero
// R16 - 5-bit fine Q offset in 0x13B bits 4:0, reset zero
// R17 - update request bit starts tuning word load, acknowledge bit reports completion
// R18 - rise and fall count byte pairs are 16-bit sequencer delays
// R19 - reserved bits read zero and ignore writes
`ifndef DCFG_CONSTS_SVH
`define DCFG_CONSTS_SVH

`define DCFG_NREG        22
`define DCFG_A_UPD       9'h113
`define DCFG_A_TUNING_WORD_BYTE3      9'h117
`define DCFG_A_TUNING_WORD_BYTE4      9'h118
`define DCFG_A_TUNING_WORD_BYTE5      9'h119
`define DCFG_A_PHOFS0    9'h11A
`define DCFG_A_PHOFS1    9'h11B
`define DCFG_A_PHCMP0    9'h11C
`define DCFG_A_PHCMP1    9'h11D
`define DCFG_A_SEQCTL    9'h11F
`define DCFG_A_RISE0     9'h121
`define DCFG_A_RISE1     9'h122
`define DCFG_A_FALL0     9'h123
`define DCFG_A_FALL1     9'h124
`define DCFG_A_SETUP     9'h12D
`define DCFG_A_TCTL      9'h12F
`define DCFG_A_TEMP0     9'h132
`define DCFG_A_TEMP1     9'h133
`define DCFG_A_TREF      9'h134
`define DCFG_A_OFSCTL    9'h135
`define DCFG_A_IC0       9'h136
`define DCFG_A_IC1       9'h137
`define DCFG_A_QC0       9'h138
`define DCFG_A_QC1       9'h139
`define DCFG_A_IFINE     9'h13A
`define DCFG_A_QFINE     9'h13B

`define DCFG_R_ZERO      8'h00
`define DCFG_R_TUNING_WORD_BYTE5      8'h10
`define DCFG_R_SEQCTL    8'h83
`define DCFG_R_RISE0     8'h0F
`define DCFG_R_FALL      8'hFF
`define DCFG_R_SETUP     8'h46
`define DCFG_R_TCTL      8'h20

`define DCFG_M_ALL       8'hFF
`define DCFG_M_BIT0      8'h01
`define DCFG_M_5BIT      8'h1F
`define DCFG_M_SEQCTL    8'hF7

`define DCFG_B_SEQ_EN    0
`define DCFG_B_PIN_SEL   1
`define DCFG_B_INVERT    2
`define DCFG_B_ACK       1

`endif

// ---- common/dcfg_pkg.sv ----
// types shared by the datapath config bank
// assumes nothing beyond the constants header
package dcfg_pkg;

    typedef logic [7:0] dcfg_byte_t;
    typedef logic [8:0] dcfg_addr_t;

    // transmit enable sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_RISE,
        SEQ_ON,
        SEQ_FALL
    } dcfg_seq_e;

endpackage

// ---- rtl/dcfg_regs.sv ----
// datapath configuration register bank with transmit sequencer
// assumes a same-clock byte register port; transmit_enable_input and temperature code are async pins
`timescale 1ns/1ps
`include "dcfg_consts.svh"

module dcfg_regs (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    // register port
    input  wire dcfg_pkg::dcfg_addr_t reg_addr_i,
    input  wire logic                 reg_wr_i,
    input  wire dcfg_pkg::dcfg_byte_t reg_wdata_i,
    input  wire logic                 reg_rd_i,
    output dcfg_pkg::dcfg_byte_t      reg_rdata_o,
    // transmit sequencer pins
    input  wire logic                 transmit_enable_input_i,
    input  wire logic                 sync_i,
    output logic                      ext_amp_pin_o,
    output logic                      amp_on_o,
    output logic [1:0]                amp_ramp_up_ctrl_o,
    output logic [1:0]                amp_ramp_down_ctrl_o,
    // oscillator
    output logic [23:0]               freq_tuning_word_o,
    output logic [15:0]               osc_phase_offset_o,
    output logic [12:0]               phase_comp_word_o,
    output dcfg_pkg::dcfg_byte_t      datapath_setup_o,
    // auxiliary converter
    output logic                      aux_converter_on_o,
    input  wire logic [15:0]          temp_code_i,
    // dc offset
    output logic                      offset_module_on_o,
    output logic [15:0]               i_coarse_offset_o,
    output logic [15:0]               q_coarse_offset_o,
    output logic [4:0]                i_fine_offset_o,
    output logic [4:0]                q_fine_offset_o
);

    // ************************************************************
    // register table
    // ************************************************************
    localparam int N = `DCFG_NREG;

    localparam dcfg_pkg::dcfg_addr_t ADDR [N] = '{
        `DCFG_A_UPD, `DCFG_A_TUNING_WORD_BYTE3, `DCFG_A_TUNING_WORD_BYTE4, `DCFG_A_TUNING_WORD_BYTE5,
        `DCFG_A_PHOFS0, `DCFG_A_PHOFS1, `DCFG_A_PHCMP0, `DCFG_A_PHCMP1,
        `DCFG_A_SEQCTL, `DCFG_A_RISE0, `DCFG_A_RISE1, `DCFG_A_FALL0,
        `DCFG_A_FALL1, `DCFG_A_SETUP, `DCFG_A_TCTL, `DCFG_A_TREF,
        `DCFG_A_OFSCTL, `DCFG_A_IC0, `DCFG_A_IC1, `DCFG_A_QC0,
        `DCFG_A_QC1, `DCFG_A_IFINE
    };

    // ordered as ADDR; fine Q is held outside the table in qfine_q
    localparam dcfg_pkg::dcfg_byte_t RST [N] = '{
        `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_TUNING_WORD_BYTE5,
        `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_ZERO,
        `DCFG_R_SEQCTL, `DCFG_R_RISE0, `DCFG_R_ZERO, `DCFG_R_FALL,
        `DCFG_R_FALL, `DCFG_R_SETUP, `DCFG_R_TCTL, `DCFG_R_ZERO,
        `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_ZERO, `DCFG_R_ZERO,
        `DCFG_R_ZERO, `DCFG_R_ZERO
    };

    localparam dcfg_pkg::dcfg_byte_t MASK [N] = '{
        `DCFG_M_BIT0, `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_ALL,
        `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_5BIT,
        `DCFG_M_SEQCTL, `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_ALL,
        `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_BIT0,
        `DCFG_M_BIT0, `DCFG_M_ALL, `DCFG_M_ALL, `DCFG_M_ALL,
        `DCFG_M_ALL, `DCFG_M_5BIT
    };

    dcfg_pkg::dcfg_byte_t regs_q [N];
    dcfg_pkg::dcfg_byte_t qfine_q;
    logic [N-1:0]         hit;
    dcfg_pkg::dcfg_byte_t rd_table;

    // ************************************************************
    // writable bytes
    // ************************************************************
    for (genvar k = 0; k < N; k++) begin : g_reg
        assign hit[k] = (reg_addr_i == ADDR[k]);
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                regs_q[k] <= RST[k]; // R01 R02 R03 R04 R05 R06 R07 R08
            end else if (reg_wr_i && hit[k]) begin
                regs_q[k] <= reg_wdata_i & MASK[k]; // R19
            end
        end
    end

    wire qfine_hit = (reg_addr_i == `DCFG_A_QFINE);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            qfine_q <= `DCFG_R_ZERO;
        end else if (reg_wr_i && qfine_hit) begin
            qfine_q <= reg_wdata_i & `DCFG_M_5BIT; // R16
        end
    end

    // table slot of an address, resolved at elaboration
    function automatic int idx_of(input dcfg_pkg::dcfg_addr_t a);
        int r;
        r = 0;
        for (int i = 0; i < N; i++) begin
            if (ADDR[i] == a) begin
                r = i;
            end
        end
        return r;
    endfunction

    always_comb begin
        rd_table = '0;
        for (int i = 0; i < N; i++) begin
            rd_table = rd_table | (hit[i] ? regs_q[i] : '0);
        end
    end

    // ************************************************************
    // field decode
    // ************************************************************
    localparam int I_UPD    = idx_of(`DCFG_A_UPD);
    localparam int I_TUNING_WORD_BYTE3   = idx_of(`DCFG_A_TUNING_WORD_BYTE3);
    localparam int I_TUNING_WORD_BYTE4   = idx_of(`DCFG_A_TUNING_WORD_BYTE4);
    localparam int I_TUNING_WORD_BYTE5   = idx_of(`DCFG_A_TUNING_WORD_BYTE5);
    localparam int I_PHOFS0 = idx_of(`DCFG_A_PHOFS0);
    localparam int I_PHOFS1 = idx_of(`DCFG_A_PHOFS1);
    localparam int I_PHCMP0 = idx_of(`DCFG_A_PHCMP0);
    localparam int I_PHCMP1 = idx_of(`DCFG_A_PHCMP1);
    localparam int I_SEQCTL = idx_of(`DCFG_A_SEQCTL);
    localparam int I_RISE0  = idx_of(`DCFG_A_RISE0);
    localparam int I_RISE1  = idx_of(`DCFG_A_RISE1);
    localparam int I_FALL0  = idx_of(`DCFG_A_FALL0);
    localparam int I_FALL1  = idx_of(`DCFG_A_FALL1);
    localparam int I_SETUP  = idx_of(`DCFG_A_SETUP);
    localparam int I_TCTL   = idx_of(`DCFG_A_TCTL);
    localparam int I_OFSCTL = idx_of(`DCFG_A_OFSCTL);
    localparam int I_IC0    = idx_of(`DCFG_A_IC0);
    localparam int I_IC1    = idx_of(`DCFG_A_IC1);
    localparam int I_QC0    = idx_of(`DCFG_A_QC0);
    localparam int I_QC1    = idx_of(`DCFG_A_QC1);
    localparam int I_IFINE  = idx_of(`DCFG_A_IFINE);

    wire dcfg_pkg::dcfg_byte_t seq_ctl  = regs_q[I_SEQCTL];
    wire                       seq_en   = seq_ctl[`DCFG_B_SEQ_EN];
    wire                       pin_sel  = seq_ctl[`DCFG_B_PIN_SEL];
    wire                       pol_flip = seq_ctl[`DCFG_B_INVERT];
    wire [15:0] rise_cnt  = {regs_q[I_RISE1], regs_q[I_RISE0]}; // R18
    wire [15:0] fall_cnt  = {regs_q[I_FALL1], regs_q[I_FALL0]}; // R18
    wire        upd_req   = regs_q[I_UPD][0];
    wire        aux_on    = regs_q[I_TCTL][0];
    wire        ofs_on    = regs_q[I_OFSCTL][0];
    wire [23:0] ftw_stage = {regs_q[I_TUNING_WORD_BYTE5], regs_q[I_TUNING_WORD_BYTE4], regs_q[I_TUNING_WORD_BYTE3]};

    assign amp_ramp_down_ctrl_o = seq_ctl[7:6]; // R08
    assign amp_ramp_up_ctrl_o   = seq_ctl[5:4]; // R08
    assign osc_phase_offset_o   = {regs_q[I_PHOFS1], regs_q[I_PHOFS0]}; // R03
    assign phase_comp_word_o    = {regs_q[I_PHCMP1][4:0], regs_q[I_PHCMP0]}; // R04
    assign datapath_setup_o     = regs_q[I_SETUP]; // R09
    assign aux_converter_on_o   = aux_on; // R10
    assign offset_module_on_o   = ofs_on; // R13

    // correction values only reach the datapath while the module is on
    assign i_coarse_offset_o = ofs_on ? {regs_q[I_IC1], regs_q[I_IC0]} : '0; // R13 R14
    assign q_coarse_offset_o = ofs_on ? {regs_q[I_QC1], regs_q[I_QC0]} : '0; // R13 R14
    assign i_fine_offset_o   = ofs_on ? regs_q[I_IFINE][4:0] : '0; // R13 R15
    assign q_fine_offset_o   = ofs_on ? qfine_q[4:0] : '0; // R13 R16

    // ************************************************************
    // tuning word update handshake
    // ************************************************************
    logic        ack_q;
    logic [23:0] ftw_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            ftw_q <= {`DCFG_R_TUNING_WORD_BYTE5, `DCFG_R_ZERO, `DCFG_R_ZERO};
        end else if (!upd_req) begin
            ack_q <= 1'b0; // R17
        end else if (!ack_q) begin
            ack_q <= 1'b1; // R17
            ftw_q <= ftw_stage; // R17
        end
    end

    assign freq_tuning_word_o = ftw_q; // R01 R02

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic        transmit_enable_input_m_q, transmit_enable_input_q;
    logic [15:0] temp_m_q, temp_s_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_enable_input_m_q <= 1'b0;
            transmit_enable_input_q   <= 1'b0;
            temp_m_q <= '0;
            temp_s_q <= '0;
        end else begin
            transmit_enable_input_m_q <= transmit_enable_input_i;
            transmit_enable_input_q   <= transmit_enable_input_m_q;
            temp_m_q <= temp_code_i;
            temp_s_q <= temp_m_q;
        end
    end

    // ************************************************************
    // temperature readback
    // ************************************************************
    logic [15:0] temp_rb_q;
    wire refresh_wr = reg_wr_i && (reg_addr_i == `DCFG_A_TREF) && reg_wdata_i[0];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_rb_q <= '0;
        end else if (refresh_wr && aux_on) begin
            temp_rb_q <= temp_s_q; // R10 R12
        end
    end

    // ************************************************************
    // transmit enable sequencer
    // ************************************************************
    dcfg_pkg::dcfg_seq_e seq_q, seq_d;
    logic [15:0]         cnt_q, cnt_d;
    logic                pin_q;

    always_comb begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        unique case (seq_q)
            dcfg_pkg::SEQ_IDLE: begin
                if (transmit_enable_input_q) begin
                    seq_d = dcfg_pkg::SEQ_RISE;
                    cnt_d = rise_cnt; // R18
                end
            end
            dcfg_pkg::SEQ_RISE: begin
                if (!transmit_enable_input_q) begin
                    seq_d = dcfg_pkg::SEQ_IDLE;
                end else if (cnt_q == '0) begin
                    seq_d = dcfg_pkg::SEQ_ON;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
            dcfg_pkg::SEQ_ON: begin
                if (!transmit_enable_input_q) begin
                    seq_d = dcfg_pkg::SEQ_FALL;
                    cnt_d = fall_cnt; // R18
                end
            end
            dcfg_pkg::SEQ_FALL: begin
                if (transmit_enable_input_q) begin
                    seq_d = dcfg_pkg::SEQ_ON;
                end else if (cnt_q == '0) begin
                    seq_d = dcfg_pkg::SEQ_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        endcase
        if (!seq_en) begin
            seq_d = dcfg_pkg::SEQ_IDLE; // R05
        end
    end

    // with the sequencer off the amplifier follows transmit_enable_input directly
    wire amp_on = seq_en ? (seq_q == dcfg_pkg::SEQ_ON || seq_q == dcfg_pkg::SEQ_FALL)
                         : transmit_enable_input_q; // R05

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q <= dcfg_pkg::SEQ_IDLE;
            cnt_q <= '0;
            pin_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            pin_q <= pin_sel ? (amp_on ^ pol_flip) : sync_i; // R06 R07
        end
    end

    assign ext_amp_pin_o = pin_q;
    assign amp_on_o      = amp_on;

    // ************************************************************
    // read port
    // ************************************************************
    dcfg_pkg::dcfg_byte_t rdata_q;
    dcfg_pkg::dcfg_byte_t rd_mux;
    wire                  ack_hit = (reg_addr_i == `DCFG_A_UPD);

    assign rd_mux = rd_table
                  | (qfine_hit ? qfine_q : '0)
                  | (ack_hit ? {6'h00, ack_q, 1'b0} : '0) // R17
                  | ((reg_addr_i == `DCFG_A_TEMP0) ? temp_rb_q[7:0] : '0) // R11
                  | ((reg_addr_i == `DCFG_A_TEMP1) ? temp_rb_q[15:8] : '0); // R11

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= rd_mux; // R19
        end
    end

    assign reg_rdata_o = rdata_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    upd_ack_a: assert property (upd_req && !ack_q |=> ack_q && ftw_q == $past(ftw_stage)) // R17
        else $error("tuning update not acknowledged with staged word");
    ack_drop_a: assert property (!upd_req |=> !ack_q) // R17
        else $error("acknowledge held without request");
    seq_off_a: assert property (!seq_en |=> seq_q == dcfg_pkg::SEQ_IDLE) // R05
        else $error("sequencer active while disabled");
    rise_load_a: assert property (seq_q == dcfg_pkg::SEQ_IDLE && transmit_enable_input_q && seq_en // R18
                                  |=> seq_q == dcfg_pkg::SEQ_RISE && cnt_q == $past(rise_cnt))
        else $error("rise delay not loaded");
    rise_done_a: assert property (seq_q == dcfg_pkg::SEQ_RISE && cnt_q == '0 && transmit_enable_input_q // R18
                                  && seq_en |=> seq_q == dcfg_pkg::SEQ_ON)
        else $error("rise delay end did not switch amplifier on");
    fall_start_a: assert property (seq_q == dcfg_pkg::SEQ_ON && !transmit_enable_input_q && seq_en // R18
                                   |=> seq_q == dcfg_pkg::SEQ_FALL && cnt_q == $past(fall_cnt))
        else $error("fall delay not loaded");
    pin_sync_a: assert property (!pin_sel |=> ext_amp_pin_o == $past(sync_i)) // R06
        else $error("shared pin not carrying sync");
    pol_flip_a: assert property (pin_sel && pol_flip |=> ext_amp_pin_o == !$past(amp_on)) // R07
        else $error("amplifier pin polarity not inverted");
    temp_cap_a: assert property (refresh_wr && aux_on |=> temp_rb_q == $past(temp_s_q)) // R12
        else $error("temperature code not captured");
    aux_gate_a: assert property (!aux_on |=> $stable(temp_rb_q)) // R10
        else $error("readback changed with converter off");
    ofs_gate_a: assert property (!ofs_on |-> i_coarse_offset_o == '0 // R13
                                 && q_coarse_offset_o == '0 && i_fine_offset_o == '0
                                 && q_fine_offset_o == '0)
        else $error("offset applied while module off");
    rsvd_read_a: assert property (reg_rd_i && reg_addr_i == `DCFG_A_IFINE // R15
                                  |=> reg_rdata_o[7:5] == 3'h0)
        else $error("reserved fine offset bits read nonzero");
    amp_direct_a: assert property (!seq_en |-> amp_on_o == transmit_enable_input_q) // R05
        else $error("amplifier not following enable with sequencer off");

    upd_seen_c:  cover property (upd_req && !ack_q ##1 ack_q);
    amp_on_c:    cover property (seq_q == dcfg_pkg::SEQ_RISE ##1 seq_q == dcfg_pkg::SEQ_ON);
    fall_end_c:  cover property (seq_q == dcfg_pkg::SEQ_FALL ##1 seq_q == dcfg_pkg::SEQ_IDLE);
    temp_cap_c:  cover property (refresh_wr && aux_on);
    direct_amp_c: cover property (!seq_en && transmit_enable_input_q);

endmodule // dcfg_regs

// ---- verification/tb_top.sv ----
// self-checking bench for the datapath config register bank
// assumes dcfg_regs on a 100 MHz clock, its header on the include path
`timescale 1ns/1ps
`include "dcfg_consts.svh"

module tb_top;
    logic                 clk_i;
    logic                 rst_n_i;
    dcfg_pkg::dcfg_addr_t reg_addr_i;
    logic                 reg_wr_i;
    dcfg_pkg::dcfg_byte_t reg_wdata_i;
    logic                 reg_rd_i;
    dcfg_pkg::dcfg_byte_t reg_rdata_o;
    logic                 transmit_enable_input_i;
    logic                 sync_i;
    logic                 ext_amp_pin_o;
    logic                 amp_on_o;
    logic [1:0]           amp_ramp_up_ctrl_o;
    logic [1:0]           amp_ramp_down_ctrl_o;
    logic [23:0]          freq_tuning_word_o;
    logic [15:0]          osc_phase_offset_o;
    logic [12:0]          phase_comp_word_o;
    dcfg_pkg::dcfg_byte_t datapath_setup_o;
    logic                 aux_converter_on_o;
    logic [15:0]          temp_code_i;
    logic                 offset_module_on_o;
    logic [15:0]          i_coarse_offset_o;
    logic [15:0]          q_coarse_offset_o;
    logic [4:0]           i_fine_offset_o;
    logic [4:0]           q_fine_offset_o;
    int                   num_errors;
    int                   n_compared;
    int                   cyc = 0;

    dcfg_regs dcfg_regs_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .transmit_enable_input_i(transmit_enable_input_i), .sync_i(sync_i),
        .ext_amp_pin_o(ext_amp_pin_o), .amp_on_o(amp_on_o),
        .amp_ramp_up_ctrl_o(amp_ramp_up_ctrl_o), .amp_ramp_down_ctrl_o(amp_ramp_down_ctrl_o),
        .freq_tuning_word_o(freq_tuning_word_o), .osc_phase_offset_o(osc_phase_offset_o),
        .phase_comp_word_o(phase_comp_word_o), .datapath_setup_o(datapath_setup_o),
        .aux_converter_on_o(aux_converter_on_o), .temp_code_i(temp_code_i),
        .offset_module_on_o(offset_module_on_o), .i_coarse_offset_o(i_coarse_offset_o),
        .q_coarse_offset_o(q_coarse_offset_o), .i_fine_offset_o(i_fine_offset_o),
        .q_fine_offset_o(q_fine_offset_o)
    );

    // ***********************************
    // helpers
    // ***********************************
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic settle();
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        settle();
        chk($sformatf("read %h", a), {16'h0000, e}, {16'h0000, reg_rdata_o});
    endtask

    task automatic wait_amp(input logic v, output int n);
        n = 0;
        while (amp_on_o !== v && n < 60) begin
            settle();
            n++;
        end
    endtask

    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ***********************************
    // scenarios
    // ***********************************
    logic [8:0] rst_a [0:19] = '{9'h113, 9'h117, 9'h118, 9'h119, 9'h11A, 9'h11B, 9'h11C,
        9'h11D, 9'h11F, 9'h121, 9'h122, 9'h123, 9'h124, 9'h12D, 9'h12F, 9'h132, 9'h133,
        9'h134, 9'h13A, 9'h13B};
    logic [7:0] rst_v [0:19] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h83, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h46, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [8:0] rw_a [0:13] = '{9'h117, 9'h11A, 9'h11D, 9'h11F, 9'h121, 9'h124, 9'h135,
        9'h136, 9'h139, 9'h13A, 9'h13B, 9'h132, 9'h133, 9'h140};
    logic [7:0] rw_v [0:13] = '{8'hFF, 8'hFF, 8'h1F, 8'hF7, 8'hFF, 8'hFF, 8'h01, 8'hFF,
        8'hFF, 8'h1F, 8'h1F, 8'h00, 8'h00, 8'h00};

    task automatic t_reset();
        chk("tuning word", 24'h10_0000, freq_tuning_word_o);
        chk("ramp ctrl", 24'h0000_02, {amp_ramp_down_ctrl_o, amp_ramp_up_ctrl_o} >> 2);
        chk("ramp up", 24'h0000_00, {22'h0, amp_ramp_up_ctrl_o});
        chk("aux on", 24'h0000_00, {23'h0, aux_converter_on_o});
        for (int i = 0; i < 20; i++) begin
            rd(rst_a[i], rst_v[i]);
        end
        $display("done reset values");
    endtask

    task automatic t_access();
        for (int i = 0; i < 14; i++) begin
            wr(rw_a[i], 8'hFF);
            rd(rw_a[i], rw_v[i]);
        end
        wr(`DCFG_A_SETUP, 8'h8B);
        settle();
        chk("setup", 24'h0000_8B, {16'h0, datapath_setup_o});
        $display("done access");
    endtask

    task automatic t_offsets();
        wr(`DCFG_A_OFSCTL, 8'h00);
        wr(`DCFG_A_IC0, 8'h34);
        wr(`DCFG_A_IC1, 8'h12);
        wr(`DCFG_A_QC0, 8'h78);
        wr(`DCFG_A_QC1, 8'h56);
        wr(`DCFG_A_IFINE, 8'hF5);
        wr(`DCFG_A_QFINE, 8'h0A);
        wr(`DCFG_A_PHOFS0, 8'hCD);
        wr(`DCFG_A_PHOFS1, 8'hAB);
        wr(`DCFG_A_PHCMP0, 8'h34);
        wr(`DCFG_A_PHCMP1, 8'hFF);
        settle();
        chk("offsets off", 24'h0, {i_coarse_offset_o | q_coarse_offset_o,
            3'b000, i_fine_offset_o | q_fine_offset_o});
        chk("phase offset", 24'h00_ABCD, {8'h0, osc_phase_offset_o});
        chk("phase comp", 24'h00_1F34, {11'h0, phase_comp_word_o});
        wr(`DCFG_A_OFSCTL, 8'h01);
        settle();
        chk("offset on", 24'h1, {23'h0, offset_module_on_o});
        chk("i coarse", 24'h00_1234, {8'h0, i_coarse_offset_o});
        chk("q coarse", 24'h00_5678, {8'h0, q_coarse_offset_o});
        chk("fines", 24'h00_150A, {3'b000, i_fine_offset_o, 3'b000, q_fine_offset_o});
        $display("done offsets");
    endtask

    task automatic t_update();
        wr(`DCFG_A_TUNING_WORD_BYTE3, 8'h11);
        wr(`DCFG_A_TUNING_WORD_BYTE4, 8'h22);
        wr(`DCFG_A_TUNING_WORD_BYTE5, 8'h33);
        settle();
        chk("word held", 24'h10_0000, freq_tuning_word_o);
        wr(`DCFG_A_UPD, 8'hFF);
        settle();
        rd(`DCFG_A_UPD, 8'h03);
        chk("word loaded", 24'h33_2211, freq_tuning_word_o);
        wr(`DCFG_A_UPD, 8'h00);
        settle();
        rd(`DCFG_A_UPD, 8'h00);
        $display("done update");
    endtask

    task automatic t_temp();
        wr(`DCFG_A_TREF, 8'h01);
        rd(`DCFG_A_TEMP0, 8'h00);
        wr(`DCFG_A_TREF, 8'h00);
        wr(`DCFG_A_TCTL, 8'h21);
        settle();
        chk("aux on", 24'h1, {23'h0, aux_converter_on_o});
        wr(`DCFG_A_TREF, 8'hFF);
        rd(`DCFG_A_TREF, 8'h01);
        rd(`DCFG_A_TEMP0, 8'hEF);
        rd(`DCFG_A_TEMP1, 8'hBE);
        $display("done temperature");
    endtask

    task automatic t_seq();
        int n;
        wr(`DCFG_A_SEQCTL, 8'h02);
        transmit_enable_input_i <= 1'b1;
        wait_amp(1'b1, n);
        chk("direct transmit_enable_input", 24'h1, {23'h0, n <= 4});
        @(posedge clk_i);
        transmit_enable_input_i <= 1'b0;
        wait_amp(1'b0, n);
        wr(`DCFG_A_RISE0, 8'h10);
        wr(`DCFG_A_RISE1, 8'h00);
        wr(`DCFG_A_FALL0, 8'h08);
        wr(`DCFG_A_FALL1, 8'h00);
        wr(`DCFG_A_SEQCTL, 8'h63);
        settle();
        chk("ramps", 24'h0000_06, {20'h0, amp_ramp_down_ctrl_o, amp_ramp_up_ctrl_o});
        @(posedge clk_i);
        transmit_enable_input_i <= 1'b1;
        wait_amp(1'b1, n);
        chk("rise delay", 24'h1, {23'h0, n >= 17 && n <= 22});
        settle();
        chk("pin amp", 24'h1, {23'h0, ext_amp_pin_o});
        wr(`DCFG_A_SEQCTL, 8'h67);
        settle();
        chk("pin invert", 24'h0, {23'h0, ext_amp_pin_o});
        wr(`DCFG_A_SEQCTL, 8'h61);
        sync_i <= 1'b1;
        settle();
        settle();
        chk("pin sync high", 24'h1, {23'h0, ext_amp_pin_o});
        @(posedge clk_i);
        sync_i <= 1'b0;
        settle();
        settle();
        chk("pin sync low", 24'h0, {23'h0, ext_amp_pin_o});
        @(posedge clk_i);
        transmit_enable_input_i <= 1'b0;
        wait_amp(1'b0, n);
        chk("fall delay", 24'h1, {23'h0, n >= 9 && n <= 14});
        $display("done sequencer");
    endtask

    // ***********************************
    // clock, reset, run
    // ***********************************
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            $display("Error timeout expected finish seen hang");
            complete_run();
        end
    end

    initial begin
        num_errors = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        reg_addr_i = 9'h000;
        reg_wr_i = 1'b0;
        reg_wdata_i = 8'h00;
        reg_rd_i = 1'b0;
        transmit_enable_input_i = 1'b0;
        sync_i = 1'b0;
        temp_code_i = 16'hBEEF;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        settle();
        t_reset();
        t_access();
        t_offsets();
        t_update();
        t_temp();
        t_seq();
        complete_run();
    end
endmodule // tb_top
